// >>> txlt_pkg.sv
// Constants for the transmit lead-time and beacon trigger register bank.
// Assumes a 32-bit AHB-Lite register bus, one word per register.
package txlt_pkg;

  // ------------------------------------------------------------
  // Register indices and byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] TXLT_IDX_SYMBOL_TICK_HIGH = 8'h15;
  localparam logic [7:0] TXLT_IDX_LEAD_CTRL = 8'h18;
  localparam logic [7:0] TXLT_IDX_BEACON_CTRL = 8'h1a;
  localparam int TXLT_ADDR_W = 10;
  localparam logic [9:0] TXLT_ADDR_SYMBOL_TICK_HIGH = {TXLT_IDX_SYMBOL_TICK_HIGH, 2'b00};
  localparam logic [9:0] TXLT_ADDR_LEAD_CTRL = {TXLT_IDX_LEAD_CTRL, 2'b00};
  localparam logic [9:0] TXLT_ADDR_BEACON_CTRL = {TXLT_IDX_BEACON_CTRL, 2'b00};

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int TXLT_QUEUE_EN_BIT = 7;
  localparam int TXLT_SYM_LSB = 2;
  localparam int TXLT_SYM_MSB = 5;
  localparam int TXLT_TICK_HI_MSB = 1;
  localparam int TXLT_TICK_LO_LSB = 1;
  localparam int TXLT_TICK_LO_MSB = 7;
  localparam int TXLT_PERIOD_HI_BIT = 0;
  localparam int TXLT_SEC_EN_BIT = 1;
  localparam int TXLT_TRIG_BIT = 0;

  // ------------------------------------------------------------
  // Reset values and limits
  // ------------------------------------------------------------
  localparam logic [3:0] TXLT_SYM_RESET = 4'h2;
  localparam logic [3:0] TXLT_SYM_MIN = 4'h1;
  localparam logic [3:0] TXLT_SYM_RECOMMENDED = 4'h6;
  localparam logic [8:0] TXLT_TICK_RESET = 9'h028;
  localparam logic TXLT_PERIOD_HI_RESET = 1'b1;
  localparam logic TXLT_QUEUE_EN_RESET = 1'b1;

  // ------------------------------------------------------------
  // Timing: lead-time tick unit against the bus clock
  // ------------------------------------------------------------
  localparam int TXLT_TICK_NS = 50;
  localparam int TXLT_HCLK_MHZ = 200;
  localparam int TXLT_TICK_CYCLES = (TXLT_TICK_NS * TXLT_HCLK_MHZ) / 1000;
  localparam int TXLT_DIV_W = 4;

endpackage : txlt_pkg

// >>> txlt_regs.sv
// Register bank for transmitter lead time, queue enable and beacon trigger.
// Assumes an AHB-Lite master on hclk and a beacon sender on the same clock.
//
// Chosen here: the AHB-Lite register port.
module txlt_regs
  import txlt_pkg::*;
(
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Beacon sender handshake
  input wire logic beacon_tx_busy,
  output logic beacon_send_start,
  // Lead-time settings to the transmitter
  output logic queue_enable,
  output logic [3:0] tx_lead_symbols,
  output logic [8:0] tx_lead_ticks,
  output logic beacon_security_enable,
  output logic tick_strobe
);
  import txlt_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr_pend;
    logic [TXLT_ADDR_W-1:0] wr_addr;
    logic [31:0] rdata;
    logic queue_en;
    logic [3:0] lead_sym;
    logic [8:0] lead_tick;
    logic period_hi;
    logic sec_en;
    logic trig;
    logic start;
    logic [TXLT_DIV_W-1:0] div;
    logic strobe;
  } txlt_state_type;

  localparam txlt_state_type TXLT_RESET_STATE = '{
    wr_pend: 1'b0, wr_addr: '0, rdata: 32'h0000_0000,
    queue_en: TXLT_QUEUE_EN_RESET, lead_sym: TXLT_SYM_RESET,
    lead_tick: TXLT_TICK_RESET, period_hi: TXLT_PERIOD_HI_RESET,
    sec_en: 1'b0, trig: 1'b0, start: 1'b0, div: '0, strobe: 1'b0};

  localparam logic [TXLT_DIV_W-1:0] DIV_LAST = TXLT_DIV_W'(TXLT_TICK_CYCLES - 1);

  txlt_state_type st;
  txlt_state_type next_st;
  logic acc;
  logic trig_wr;

  // ------------------------------------------------------------
  // Read decode, shared by the read path
  // ------------------------------------------------------------
  function automatic logic [31:0] read_word(input txlt_state_type s,
                                            input logic [TXLT_ADDR_W-1:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      TXLT_ADDR_LEAD_CTRL: begin
        // Reserved bit 6 reads as zero
        w[TXLT_QUEUE_EN_BIT] = s.queue_en;
        w[TXLT_SYM_MSB:TXLT_SYM_LSB] = s.lead_sym;
        w[TXLT_TICK_HI_MSB:0] = s.lead_tick[8:7];
      end
      TXLT_ADDR_SYMBOL_TICK_HIGH: begin
        w[TXLT_TICK_LO_MSB:TXLT_TICK_LO_LSB] = s.lead_tick[6:0];
        w[TXLT_PERIOD_HI_BIT] = s.period_hi;
      end
      TXLT_ADDR_BEACON_CTRL: begin
        w[TXLT_SEC_EN_BIT] = s.sec_en;
        w[TXLT_TRIG_BIT] = s.trig;
      end
      default: w = 32'h0000_0000; // Unmapped words read zero, OKAY
    endcase
    return w;
  endfunction : read_word

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  assign acc = hsel && hready && htrans[1];
  // Data phase of a write that puts a one on the trigger bit
  assign trig_wr = st.wr_pend && (st.wr_addr == TXLT_ADDR_BEACON_CTRL) && hwdata[TXLT_TRIG_BIT];

  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    // Address phase: reads are answered from the current contents
    next_st.wr_pend = acc && hwrite;
    if (acc) begin
      next_st.wr_addr = haddr[TXLT_ADDR_W-1:0];
      if (!hwrite) begin
        next_st.rdata = read_word(st, haddr[TXLT_ADDR_W-1:0]);
      end
    end
    // Tick divider: one strobe per 50 ns of the 200 MHz bus clock
    next_st.strobe = (st.div == DIV_LAST);
    next_st.div = (st.div == DIV_LAST) ? '0 : st.div + 1'b1;
    // Launch a pending beacon only while the sender is idle
    if (st.trig && !beacon_tx_busy && !st.start) begin
      next_st.start = 1'b1;
      next_st.trig = 1'b0;
    end
    // Data phase write; ignoring reserved bits keeps them zero
    if (st.wr_pend) begin
      unique case (st.wr_addr)
        TXLT_ADDR_LEAD_CTRL: begin
          next_st.queue_en = hwdata[TXLT_QUEUE_EN_BIT];
          next_st.lead_sym = hwdata[TXLT_SYM_MSB:TXLT_SYM_LSB];
          next_st.lead_tick[8:7] = hwdata[TXLT_TICK_HI_MSB:0];
        end
        TXLT_ADDR_SYMBOL_TICK_HIGH: begin
          next_st.lead_tick[6:0] = hwdata[TXLT_TICK_LO_MSB:TXLT_TICK_LO_LSB];
          next_st.period_hi = hwdata[TXLT_PERIOD_HI_BIT];
        end
        TXLT_ADDR_BEACON_CTRL: begin
          next_st.sec_en = hwdata[TXLT_SEC_EN_BIT];
          // A one sets and wins over the hardware clear; a zero is ignored
          if (hwdata[TXLT_TRIG_BIT]) begin
            next_st.trig = 1'b1;
          end
        end
        default: next_st.trig = next_st.trig; // Unmapped writes are dropped
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register, frozen while ce is low
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= TXLT_RESET_STATE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs; zero-wait slave, so ready is a flop held high after reset and response is tied to OKAY
  // ------------------------------------------------------------
  // Ready ignores ce so that a frozen bank never stalls the shared bus
  logic ready_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= 1'b1;
    end
  end

  // Symbol count below the minimum would give no lead at all, so floor it
  logic [3:0] sym_eff_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sym_eff_q <= TXLT_SYM_RESET;
    end else if (ce) begin
      sym_eff_q <= (next_st.lead_sym < TXLT_SYM_MIN) ? TXLT_SYM_MIN : next_st.lead_sym;
    end
  end

  assign hrdata = st.rdata;
  assign hreadyout = ready_q;
  assign hresp = 1'b0;
  assign beacon_send_start = st.start;
  assign queue_enable = st.queue_en;
  assign tx_lead_symbols = sym_eff_q;
  assign tx_lead_ticks = st.lead_tick;
  assign beacon_security_enable = st.sec_en;
  assign tick_strobe = st.strobe;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // Helper: ce cycles since the last tick strobe, checked against the tick length
  logic [TXLT_DIV_W-1:0] gap_q;
  logic gap_seen_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_q <= '0;
      gap_seen_q <= 1'b0;
    end else if (ce) begin
      gap_q <= tick_strobe ? '0 : gap_q + 1'b1;
      gap_seen_q <= gap_seen_q | tick_strobe;
    end
  end

  // Trigger and launch; a one written in the launch cycle re-arms the trigger
  a_trig_launches: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && st.trig && !beacon_tx_busy && !st.start)
      |=> st.start && (st.trig == $past(trig_wr)))
    else $error("pending trigger did not launch");

  a_start_one_cycle: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && st.start) |=> !st.start)
    else $error("send start longer than one cycle");

  a_zero_no_effect: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !st.trig && !(st.wr_pend && st.wr_addr == TXLT_ADDR_BEACON_CTRL
      && hwdata[TXLT_TRIG_BIT])) |=> !st.trig && !st.start)
    else $error("trigger set without a one written");

  a_trig_held_busy: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && st.trig && beacon_tx_busy) |=> st.trig)
    else $error("trigger lost while sender busy");

  a_sym_floor: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_lead_symbols >= TXLT_SYM_MIN)
    else $error("lead symbols below minimum");

  a_sec_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && st.wr_pend && st.wr_addr == TXLT_ADDR_BEACON_CTRL)
      |=> beacon_security_enable == $past(hwdata[TXLT_SEC_EN_BIT]))
    else $error("security enable not written");

  a_tick_lo_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && st.wr_pend && st.wr_addr == TXLT_ADDR_SYMBOL_TICK_HIGH)
      |=> tx_lead_ticks[6:0] == $past(hwdata[7:1]))
    else $error("low tick bits not written");

  a_tick_hi_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && st.wr_pend && st.wr_addr == TXLT_ADDR_LEAD_CTRL)
      |=> tx_lead_ticks[8:7] == $past(hwdata[1:0]) && queue_enable == $past(hwdata[7]))
    else $error("high tick bits or queue enable not written");

  a_strobe_period: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && tick_strobe) |=> !tick_strobe)
    else $error("tick strobe too wide");

  // Tick timing: one strobe per tick length, counted in enabled cycles
  a_tick_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
    (gap_seen_q && tick_strobe) |-> gap_q == DIV_LAST)
    else $error("tick strobe spacing wrong");

  a_tick_gap_max: assert property (@(posedge hclk) disable iff (!hresetn)
    (gap_seen_q && !tick_strobe) |-> gap_q < DIV_LAST)
    else $error("tick strobe missing");

  a_reset_lead: assert property (@(posedge hclk)
    $rose(hresetn) |-> tx_lead_ticks == TXLT_TICK_RESET && queue_enable)
    else $error("lead-time reset value wrong");

  a_reset_beacon: assert property (@(posedge hclk)
    $rose(hresetn) |-> !beacon_security_enable && !beacon_send_start)
    else $error("beacon control reset value wrong");

  // Writes, reads and holds of the settings
  a_sym_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && st.wr_pend && st.wr_addr == TXLT_ADDR_LEAD_CTRL
      && hwdata[TXLT_SYM_MSB:TXLT_SYM_LSB] >= TXLT_SYM_MIN)
      |=> tx_lead_symbols == $past(hwdata[TXLT_SYM_MSB:TXLT_SYM_LSB]))
    else $error("lead symbols not written");

  a_lead_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && acc && !hwrite && haddr[TXLT_ADDR_W-1:0] == TXLT_ADDR_LEAD_CTRL)
      |=> hrdata[TXLT_QUEUE_EN_BIT] == $past(queue_enable) && hrdata[TXLT_SYM_MSB+1] == 1'b0
        && hrdata[31:TXLT_QUEUE_EN_BIT+1] == '0)
    else $error("lead register read wrong");

  a_sec_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !(st.wr_pend && st.wr_addr == TXLT_ADDR_BEACON_CTRL))
      |=> $stable(beacon_security_enable))
    else $error("security enable changed without a write");

  a_lead_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !(st.wr_pend && (st.wr_addr == TXLT_ADDR_LEAD_CTRL
      || st.wr_addr == TXLT_ADDR_SYMBOL_TICK_HIGH))) |=> $stable(tx_lead_ticks))
    else $error("lead ticks changed without a write");

  c_beacon_send: cover property (@(posedge hclk) disable iff (!hresetn) st.start);
  c_busy_wait: cover property (@(posedge hclk) disable iff (!hresetn)
    st.trig && beacon_tx_busy ##1 st.trig);
  c_lead_write: cover property (@(posedge hclk) disable iff (!hresetn)
    st.wr_pend && st.wr_addr == TXLT_ADDR_LEAD_CTRL);
  c_sym_floor: cover property (@(posedge hclk) disable iff (!hresetn)
    st.wr_pend && st.wr_addr == TXLT_ADDR_LEAD_CTRL && hwdata[TXLT_SYM_MSB:TXLT_SYM_LSB] == 4'h0);
  c_ce_frozen: cover property (@(posedge hclk) disable iff (!hresetn)
    !ce && acc);

endmodule : txlt_regs

// >>> tb_top.sv
// Self-checking bench for the lead-time and beacon trigger register bank.
// Assumes txlt_pkg is compiled first; this bench is the only bus master.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import txlt_pkg::*;

  // ------------------------------------------------------------
  // Signals and bookkeeping
  // ------------------------------------------------------------
  logic hclk;
  logic hresetn;
  logic ce;
  logic hsel;
  logic hwrite;
  logic hready;
  logic beacon_tx_busy;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout;
  logic hresp;
  logic beacon_send_start;
  logic queue_enable;
  logic beacon_security_enable;
  logic tick_strobe;
  logic [3:0] tx_lead_symbols;
  logic [8:0] tx_lead_ticks;
  int n_errors;
  int num_checks;
  int cycles;
  int n_starts;
  localparam logic [31:0] A_TICK = {22'h0, TXLT_ADDR_SYMBOL_TICK_HIGH};
  localparam logic [31:0] A_LEAD = {22'h0, TXLT_ADDR_LEAD_CTRL};
  localparam logic [31:0] A_BCN = {22'h0, TXLT_ADDR_BEACON_CTRL};

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  txlt_regs txlt_regs_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .beacon_tx_busy(beacon_tx_busy),
    .beacon_send_start(beacon_send_start), .queue_enable(queue_enable),
    .tx_lead_symbols(tx_lead_symbols), .tx_lead_ticks(tx_lead_ticks),
    .beacon_security_enable(beacon_security_enable), .tick_strobe(tick_strobe)
  );

  // 200 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // Start pulses are counted on the falling edge, away from flop updates
  always @(negedge hclk) begin
    cycles++;
    if (beacon_send_start === 1'b1) n_starts++;
    if (cycles == 4000) begin
      n_errors++;
      complete_run();
    end
  end

  task complete_run;
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One AHB-Lite single transfer; waits on hready rather than assuming latency
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task reset_values;
    rdchk("tick_high", A_TICK, {24'h0, TXLT_TICK_RESET[6:0], 1'b1});
    rdchk("lead_ctrl", A_LEAD, 32'h0000_0088);
    rdchk("beacon_ctrl", A_BCN, 32'h0000_0000);
    chk("queue_enable", 32'h1, 32'(queue_enable));
    chk("symbols", 32'h2, 32'(tx_lead_symbols));
    chk("ticks", 32'h028, 32'(tx_lead_ticks));
    chk("security", 32'h0, 32'(beacon_security_enable));
  endtask : reset_values

  // Both halves of the tick count, symbol floor, frozen clock enable; reserved bits written 0
  task lead_fields;
    xfer(1'b1, A_LEAD, 32'h0000_009b);
    xfer(1'b1, A_TICK, 32'h0000_00fe);
    rdchk("lead_ctrl", A_LEAD, 32'h0000_009b);
    chk("symbols", 32'h6, 32'(tx_lead_symbols));
    chk("ticks", 32'h1ff, 32'(tx_lead_ticks));
    xfer(1'b1, A_LEAD, 32'h0000_0080);
    rdchk("lead_ctrl", A_LEAD, 32'h0000_0080);
    chk("symbols floor", {28'h0, TXLT_SYM_MIN}, 32'(tx_lead_symbols));
    chk("ticks", 32'h07f, 32'(tx_lead_ticks));
    chk("queue_enable", 32'h1, 32'(queue_enable));
    ce <= 1'b0;
    xfer(1'b1, A_LEAD, 32'h0000_008c);
    ce <= 1'b1;
    xfer(1'b1, 32'h0000_0070, 32'h0000_00ff);
    rdchk("unmapped", 32'h0000_0070, 32'h0);
    rdchk("lead_ctrl held", A_LEAD, 32'h0000_0080);
  endtask : lead_fields

  // Trigger with the sender idle, then a zero trigger with reserved bits kept zero
  task beacon_free;
    int s;
    s = n_starts;
    xfer(1'b1, A_BCN, 32'h0000_0003);
    repeat (4) @(posedge hclk);
    chk("starts", 32'(s + 1), 32'(n_starts));
    chk("security", 32'h1, 32'(beacon_security_enable));
    rdchk("beacon_ctrl", A_BCN, 32'h0000_0002);
    xfer(1'b1, A_BCN, 32'h0000_0000);
    chk("hresp", 32'h0, 32'(hresp));
    repeat (4) @(posedge hclk);
    chk("starts", 32'(s + 1), 32'(n_starts));
    rdchk("beacon_ctrl", A_BCN, 32'h0000_0000);
  endtask : beacon_free

  // Trigger held while the sender is busy; a zero write must not cancel it
  task beacon_busy;
    int s;
    s = n_starts;
    beacon_tx_busy <= 1'b1;
    xfer(1'b1, A_BCN, 32'h0000_0003);
    repeat (4) @(posedge hclk);
    chk("starts busy", 32'(s), 32'(n_starts));
    xfer(1'b1, A_BCN, 32'h0000_0002);
    rdchk("beacon_ctrl", A_BCN, 32'h0000_0003);
    beacon_tx_busy <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("starts", 32'(s + 1), 32'(n_starts));
    rdchk("beacon_ctrl", A_BCN, 32'h0000_0002);
  endtask : beacon_busy

  // Tick strobe spacing: 50 ns at a 5 ns clock
  task tick_rate;
    int n;
    n = 0;
    do @(negedge hclk); while (tick_strobe !== 1'b1);
    do begin
      @(negedge hclk);
      n++;
    end while (tick_strobe !== 1'b1 && n < 40);
    chk("tick period", 32'(50 / 5), 32'(n));
  endtask : tick_rate

  // Reset in mid-run brings every setting back to its reset value
  task mid_reset;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("queue_enable", 32'h1, 32'(queue_enable));
    chk("symbols", {28'h0, TXLT_SYM_RESET}, 32'(tx_lead_symbols));
    chk("ticks", {23'h0, TXLT_TICK_RESET}, 32'(tx_lead_ticks));
    chk("security", 32'h0, 32'(beacon_security_enable));
    rdchk("beacon_ctrl", A_BCN, 32'h0000_0000);
  endtask : mid_reset

  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    beacon_tx_busy = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    reset_values();
    lead_fields();
    beacon_free();
    beacon_busy();
    tick_rate();
    mid_reset();
    complete_run();
  end
endmodule : tb_top
